// ### design/cmp_bcd_consts.svh
/*
  Constants for the compare-skip and decimal adjust execution block.
  Assumes it is included by bare name from the design files.
*/
`ifndef CMP_BCD_CONSTS_SVH
`define CMP_BCD_CONSTS_SVH

// Compare-and-skip opcode: fixed top seven bits, then access bit, then address
`define CSL_OPC_TOP     7'h30
`define CSL_TOP_MSB     15
`define CSL_TOP_LSB     9
`define CSL_ACCESS_BIT  8
// Decimal adjust opcode, no operand
`define DAA_OPC         16'h0007
// Decimal adjust limits
`define BCD_DIGIT_MAX   4'h9
`define BCD_CORRECTION  5'h06
// Access bank split point and default banks
`define ACCESS_SPLIT    8'h60
`define ACCESS_LO_BANK  6'h00
`define ACCESS_HI_BANK  6'h3F
// Words of a skipped instruction after reset
`define SKIP_NONE       2'h0

`endif

// ### design/cmp_bcd_pkg.sv
/*
  Types for the compare-skip and decimal adjust execution block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cmp_bcd_pkg;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

  typedef enum logic [1:0] {OP_NONE, OP_CMP_LESS, OP_DEC_ADJ} op_t;

endpackage

// ### design/alu_if.sv
/*
  Interface between the sequencer and the data path.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps

interface alu_if;
  import cmp_bcd_pkg::*;

  op_t        op;
  logic [7:0] file_data;
  logic [7:0] w_val;
  logic       carry;
  logic       digit_carry;
  logic       less;
  logic [7:0] w_res;
  logic       carry_res;

  modport core
  (
    output op,
    output file_data,
    output w_val,
    output carry,
    output digit_carry,
    input  less,
    input  w_res,
    input  carry_res
  );

  modport alu
  (
    input  op,
    input  file_data,
    input  w_val,
    input  carry,
    input  digit_carry,
    output less,
    output w_res,
    output carry_res
  );
endinterface

// ### design/cmp_bcd_alu.sv
/*
  Data path: unsigned compare and packed BCD correction.
  Assumes operands held stable by the sequencer and the core during the process phase.
*/
`timescale 1ns/1ps
`include "cmp_bcd_consts.svh"

module cmp_bcd_alu
  import cmp_bcd_pkg::*;
(
  // Operands and results
  alu_if.alu  bus
);

  logic [8:0] diff;
  logic [4:0] lo_sum;
  logic [4:0] hi_sum;
  logic [4:0] hi_res;
  logic       lo_adj;
  logic       hi_adj;
  logic       dc_eff;

  // Borrow of the subtraction is the result; the difference is dropped
  assign diff     = {1'b0, bus.file_data} - {1'b0, bus.w_val};
  assign bus.less = (bus.op == OP_CMP_LESS) && diff[8];

  assign lo_adj = (bus.w_val[3:0] > `BCD_DIGIT_MAX) | bus.digit_carry;
  assign lo_sum = lo_adj ? {1'b0, bus.w_val[3:0]} + `BCD_CORRECTION
                         : {1'b0, bus.w_val[3:0]};
  // Low digit overflow counts as a digit carry, so a raw sum is corrected fully
  assign dc_eff = bus.digit_carry | lo_sum[4];
  assign hi_sum = {1'b0, bus.w_val[7:4]} + {4'h0, dc_eff};
  assign hi_adj = (hi_sum > {1'b0, `BCD_DIGIT_MAX}) | bus.carry;
  assign hi_res = hi_adj ? hi_sum + `BCD_CORRECTION : hi_sum;

  assign bus.w_res     = {hi_res[3:0], lo_sum[3:0]};
  assign bus.carry_res = bus.carry | hi_adj | hi_res[4];

endmodule

// ### design/compare_skip_and_bcd_adjust.sv
/*
  Execution of the compare-skip-if-less and decimal adjust instructions,
  sequenced over four phases per instruction cycle.
  Assumes the fetch logic presents the opcode at phase one, the word count
  of the following instruction, and a data memory that answers one clock
  after a read strobe. All inputs come from logic on the same clock.
*/
//Contract
//- Unsigned compare, no flags changed
//- Less discards next instruction, runs nop
//- Decode compare from fixed seven opcode bits
//- Access bit selects access or selected bank
//- Compare one word, one to four cycles
//- Skipped words each cost one nop cycle
//- Low nibble plus six when above nine
//- High nibble adjust; only carry changes
//- Decimal adjust: fixed opcode, one cycle
//- Result written back as packed BCD
`timescale 1ns/1ps
`include "cmp_bcd_consts.svh"

module compare_skip_and_bcd_adjust
  import cmp_bcd_pkg::*;
#(
  parameter int BANK_W = 6
)
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Fetched instruction
  input  wire logic [15:0]       ir_word,
  input  wire logic              ir_valid,
  input  wire logic [1:0]        next_words,
  // Core state
  input  wire logic [7:0]        w_in,
  input  wire logic              carry_in,
  input  wire logic              digit_carry_in,
  input  wire logic [BANK_W-1:0] bank_selector,
  // Data memory
  input  wire logic [7:0]        mem_rdata,
  output logic [BANK_W+7:0]      mem_addr_q,
  output logic                   mem_rd_q,
  // Results
  output logic [7:0]             w_q,
  output logic                   w_wr_q,
  output logic                   carry_q,
  output logic                   carry_wr_q,
  // Sequencing
  output phase_t                 phase_q,
  output logic                   discard_q,
  output logic                   ready_q
);

  alu_if  alu_bus ();

  op_t        op_q;
  logic       access_q;
  logic [7:0] faddr_q;
  logic [7:0] fdata_q;
  logic [1:0] skip_cnt_q;
  logic       busy;
  logic       is_cmp_word;
  logic       take_skip;

  cmp_bcd_alu u_alu
  (
    .bus (alu_bus.alu)
  );

  // W and flags come straight from the core and must hold through the process phase
  assign alu_bus.op          = op_q;
  assign alu_bus.file_data   = fdata_q;
  assign alu_bus.w_val       = w_in;
  assign alu_bus.carry       = carry_in;
  assign alu_bus.digit_carry = digit_carry_in;

  assign busy = (skip_cnt_q != `SKIP_NONE);

  // Words arriving in skip cycles are never decoded, so they cannot strobe memory
  assign is_cmp_word = ir_valid && !busy
                       && ir_word[`CSL_TOP_MSB:`CSL_TOP_LSB] == `CSL_OPC_TOP;
  // Less is raised by the data path only while a compare is in hand
  assign take_skip   = alu_bus.less && !busy;

  // Phase counter: one clock per phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_q <= PH_Q1;
    else if (clk_en)
    begin
      case (phase_q)
        PH_Q1:   phase_q <= PH_Q2;
        PH_Q2:   phase_q <= PH_Q3;
        PH_Q3:   phase_q <= PH_Q4;
        default: phase_q <= PH_Q1;
      endcase
    end
  end

  // Decode in the first phase; a discarded word is never decoded
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_q     <= OP_NONE;
      access_q <= 1'b0;
      faddr_q  <= 8'h00;
    end
    else if (clk_en && phase_q == PH_Q1)
    begin
      access_q <= ir_word[`CSL_ACCESS_BIT];
      faddr_q  <= ir_word[7:0];
      if (!ir_valid || busy)
        op_q <= OP_NONE;
      else if (ir_word[`CSL_TOP_MSB:`CSL_TOP_LSB] == `CSL_OPC_TOP)
        op_q <= OP_CMP_LESS;
      else if (ir_word == `DAA_OPC)
        op_q <= OP_DEC_ADJ;
      else
        op_q <= OP_NONE;
    end
  end

  // Operand read in the second phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mem_rd_q   <= 1'b0;
      mem_addr_q <= '0;
    end
    else if (clk_en)
    begin
      mem_rd_q <= (phase_q == PH_Q1) && is_cmp_word;
      if (phase_q == PH_Q1)
      begin
        if (ir_word[`CSL_ACCESS_BIT])
          mem_addr_q <= {bank_selector, ir_word[7:0]};
        else if (ir_word[7:0] < `ACCESS_SPLIT)
          mem_addr_q <= {BANK_W'(`ACCESS_LO_BANK), ir_word[7:0]};
        else
          mem_addr_q <= {BANK_W'(`ACCESS_HI_BANK), ir_word[7:0]};
      end
    end
  end

  // Memory answers one clock after the strobe, i.e. at the third phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fdata_q <= 8'h00;
    else if (clk_en && phase_q == PH_Q3 && op_q == OP_CMP_LESS)
      fdata_q <= mem_rdata;
  end

  // Write-back in the fourth phase; compare writes nothing
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      w_q        <= 8'h00;
      w_wr_q     <= 1'b0;
      carry_q    <= 1'b0;
      carry_wr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      w_wr_q     <= (phase_q == PH_Q3) && op_q == OP_DEC_ADJ;
      carry_wr_q <= (phase_q == PH_Q3) && op_q == OP_DEC_ADJ;
      if (phase_q == PH_Q3 && op_q == OP_DEC_ADJ)
      begin
        w_q     <= alu_bus.w_res;
        carry_q <= alu_bus.carry_res;
      end
    end
  end

  // Skip: one nop cycle per word of the following instruction
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      skip_cnt_q <= `SKIP_NONE;
    else if (clk_en && phase_q == PH_Q4)
    begin
      // A count of zero means no skip; fetch must report one to three words
      if (take_skip)
        skip_cnt_q <= next_words;
      else if (busy)
        skip_cnt_q <= skip_cnt_q - 2'h1;
    end
  end

  // Discard marker and readiness are valid over the whole following cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      discard_q <= 1'b0;
      ready_q   <= 1'b1;
    end
    else if (clk_en && phase_q == PH_Q4)
    begin
      if (take_skip)
      begin
        discard_q <= (next_words != `SKIP_NONE);
        ready_q   <= (next_words == `SKIP_NONE);
      end
      else if (busy)
      begin
        discard_q <= (skip_cnt_q != 2'h1);
        ready_q   <= (skip_cnt_q == 2'h1);
      end
      else
      begin
        discard_q <= 1'b0;
        ready_q   <= 1'b1;
      end
    end
  end

endmodule

// ### sim/cmp_bcd_chk.sv
/*
  Port checker for the compare-skip and decimal adjust block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps

module cmp_bcd_chk
  import cmp_bcd_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Observed outputs
  input wire logic mem_rd_q,
  input wire logic w_wr_q,
  input wire logic carry_wr_q,
  input wire phase_t phase_q,
  input wire logic discard_q,
  input wire logic ready_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RD_IN_Q2:
    assert property (mem_rd_q |-> phase_q == PH_Q2 ##1 !mem_rd_q) else $error("read off Q2");
  AST_WR_IN_Q4:
    assert property (w_wr_q |-> phase_q == PH_Q4) else $error("write off Q4");
  AST_CARRY_PAIR:
    assert property (w_wr_q == carry_wr_q) else $error("carry write unpaired");
  AST_CMP_NO_WR:
    assert property (mem_rd_q |-> ##2 !w_wr_q && !carry_wr_q) else $error("compare wrote");
  AST_PHASE_STEP:
    assert property (clk_en |=> phase_q == phase_t'($past(phase_q) + 2'h1))
      else $error("phase skipped");
  AST_SKIP_AT_Q1:
    assert property ($rose(discard_q) |-> phase_q == PH_Q1) else $error("skip mid-cycle");
  AST_SKIP_CAUSE:
    assert property ($rose(discard_q) |-> $past(mem_rd_q, 3)) else $error("skip w/o compare");
  AST_SKIP_IDLE:
    assert property (discard_q |-> !ready_q && !mem_rd_q && !w_wr_q) else $error("nop acted");
endmodule

// ### sim/tb_top.sv
/*
  Self-checking bench: corner and random instructions, skip counts.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps
`include "cmp_bcd_consts.svh"

module tb_top
  import cmp_bcd_pkg::*;
;
  logic clk, sys_rst, clk_en, ir_valid, carry_in, digit_carry_in;
  logic [15:0] ir_word;
  logic [1:0] next_words;
  logic [7:0] w_in, mem_rdata, w_q;
  logic [5:0] bank_selector;
  logic [13:0] mem_addr_q;
  logic mem_rd_q, w_wr_q, carry_q, carry_wr_q, discard_q, ready_q;
  phase_t phase_q;
  int fails, checked, seed, n, r;

  compare_skip_and_bcd_adjust dut
  (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .ir_word(ir_word),
    .ir_valid(ir_valid), .next_words(next_words), .w_in(w_in), .carry_in(carry_in),
    .digit_carry_in(digit_carry_in), .bank_selector(bank_selector),
    .mem_rdata(mem_rdata), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q), .w_q(w_q),
    .w_wr_q(w_wr_q), .carry_q(carry_q), .carry_wr_q(carry_wr_q), .phase_q(phase_q),
    .discard_q(discard_q), .ready_q(ready_q)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Low nibble overflow feeds the high nibble as digit carry, alongside the flag
  function automatic logic [8:0] daw_exp(input logic [7:0] w, input logic c, input logic dc);
    logic [4:0] lo, hi;
    logic adj;
    lo = {1'b0, w[3:0]} + ((w[3:0] > 4'h9 || dc) ? 5'h06 : 5'h00);
    hi = {1'b0, w[7:4]} + {4'h0, dc | lo[4]};
    adj = hi > 5'h09 || c;
    hi = hi + (adj ? 5'h06 : 5'h00);
    return {c | adj | hi[4], hi[3:0], lo[3:0]};
  endfunction

  task automatic instr(input logic [15:0] iw, input logic [7:0] w, input logic [7:0] md,
                       input logic c, input logic dc, input logic [1:0] nw);
    logic [8:0] e;
    logic [13:0] ea;
    logic cmp, daa, lt;
    cmp = ir_valid && iw[15:9] == `CSL_OPC_TOP;
    daa = ir_valid && iw == `DAA_OPC;
    lt = cmp && md < w;
    e = daw_exp(w, c, dc);
    while (phase_q !== PH_Q1) @(negedge clk);
    bank_selector = 6'($random(seed));
    ea = iw[8] ? {bank_selector, iw[7:0]}
       : {iw[7:0] < `ACCESS_SPLIT ? `ACCESS_LO_BANK : `ACCESS_HI_BANK, iw[7:0]};
    {ir_word, w_in, mem_rdata, carry_in, digit_carry_in, next_words} = {iw, w, md, c, dc, nw};
    @(negedge clk);
    chk(mem_rd_q, cmp);
    if (cmp) chk(mem_addr_q, ea);
    repeat (2) @(negedge clk);
    chk(w_wr_q, daa);
    chk(carry_wr_q, daa);
    if (daa) chk({carry_q, w_q}, e);
    // Present a valid opcode in skip cycles: it must not run
    ir_word = `DAA_OPC;
    @(negedge clk);
    n = 0;
    while (discard_q === 1'b1 && n < 16)
    begin
      chk({w_wr_q, ready_q}, 2'b00);
      n++;
      @(negedge clk);
    end
    chk(n, lt ? 4 * nw : 0);
    chk(ready_q, 1'b1);
  endtask

  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #(25 * 6000);
    fails++;
    complete_run();
  end

  initial
  begin
    seed = 10;
    {sys_rst, clk_en, ir_valid, ir_word, w_in, mem_rdata} = {3'b111, 32'h0};
    {carry_in, digit_carry_in, next_words, bank_selector} = 10'h0;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    instr(`DAA_OPC, 8'hA5, 8'h00, 1'b0, 1'b0, 2'h1);
    instr(`DAA_OPC, 8'hCE, 8'h00, 1'b0, 1'b0, 2'h1);
    instr(`DAA_OPC, 8'h19, 8'h00, 1'b0, 1'b1, 2'h1);
    $display("decimal adjust corners done");
    for (int k = 1; k < 4; k++)
      instr({`CSL_OPC_TOP, 9'h05F}, 8'h80, 8'h7F, 1'b0, 1'b0, 2'(k));
    instr({`CSL_OPC_TOP, 9'h060}, 8'h42, 8'h42, 1'b1, 1'b0, 2'h1);
    instr(16'h6200, 8'hFF, 8'h00, 1'b0, 1'b0, 2'h1);
    $display("compare corners done");
    // Enable low in mid-instruction freezes phase and result
    while (phase_q !== PH_Q1) @(negedge clk);
    {ir_word, w_in, carry_in, digit_carry_in} = {`DAA_OPC, 8'h9A, 2'b00};
    @(negedge clk);
    clk_en = 1'b0;
    repeat (3) @(negedge clk);
    chk({phase_q, w_wr_q}, {PH_Q2, 1'b0});
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    chk({carry_q, w_q, w_wr_q}, {daw_exp(8'h9A, 1'b0, 1'b0), 1'b1});
    // Reset in the middle of a skip: idle at once, next word runs normally
    while (phase_q !== PH_Q1) @(negedge clk);
    {ir_word, w_in, mem_rdata, next_words} = {`CSL_OPC_TOP, 9'h010, 8'hFF, 8'h00, 2'h3};
    repeat (6) @(negedge clk);
    chk(discard_q, 1'b1);
    sys_rst = 1'b1;
    @(negedge clk);
    chk({phase_q, discard_q, ready_q, mem_rd_q, w_wr_q}, {PH_Q1, 4'b0100});
    sys_rst = 1'b0;
    $display("enable and reset corners done");
    for (int k = 0; k < 50; k++)
    begin
      r = $random(seed);
      ir_valid = r[31:30] != 2'b00;
      instr(r[0] ? `DAA_OPC : {`CSL_OPC_TOP, r[9:1]}, r[17:10], r[25:18], r[26], r[27],
            2'(1 + r[29:28] % 3));
    end
    $display("random instructions done");
    complete_run();
  end
endmodule

bind compare_skip_and_bcd_adjust cmp_bcd_chk chk
(
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .mem_rd_q(mem_rd_q), .w_wr_q(w_wr_q),
  .carry_wr_q(carry_wr_q), .phase_q(phase_q), .discard_q(discard_q), .ready_q(ready_q)
);
